// ===== rtl/irq_enable_priority_regs.sv
`timescale 1ns/100ps
// interrupt mask and two-level priority registers with request selection
module irq_enable_priority_regs
   import irq_regs_pkg::*;
#(
   parameter int N_SRC = NUM_SRC
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   // special-function register access from the core
   input  wire logic [7:0]       sfr_addr_i,
   input  wire logic             sfr_wr_i,
   input  wire logic [7:0]       sfr_wdata_i,
   input  wire logic             sfr_rd_i,
   output logic      [7:0]       sfr_rdata_o,
   output logic                  sfr_hit_o,
   // basic enable state kept elsewhere
   input  wire logic             global_irq_gate_i,
   input  wire logic [6:0]       basic_enable_i,
   // pending flags of the base sources, vector order 0..6
   input  wire logic [6:0]       base_pending_i,
   // pending flags of the extended sources
   input  wire logic             smbus_pending_i,
   input  wire logic             rtc_alarm_flag_i,
   input  wire logic             rtc_osc_failure_flag_i,
   input  wire logic             window_compare_flag_i,
   input  wire logic             conversion_done_flag_i,
   input  wire logic             counter_array_pending_i,
   input  wire logic             comparator_zero_rise_flag_i,
   input  wire logic             comparator_zero_fall_flag_i,
   input  wire logic             comparator_one_rise_flag_i,
   input  wire logic             comparator_one_fall_flag_i,
   input  wire logic             timer_three_low_overflow_i,
   input  wire logic             timer_three_high_overflow_i,
   // core service handshake
   input  wire logic             irq_ack_i,
   input  wire logic             reti_i,
   input  wire logic             instr_done_i,
   output logic                  irq_req_o,
   output logic      [VEC_W-1:0] irq_vector_o,
   output logic                  irq_high_o,
   // request view per source and in-service view per level
   output logic      [14:0]      gated_req_o,
   output logic                  in_service_high_o,
   output logic                  in_service_low_o
);

   generate
      if (N_SRC != NUM_SRC) begin : g_bad_src
         $error("irq_enable_priority_regs: source count is fixed at 15");
      end
      if (NUM_BASE_SRC + 8 != NUM_SRC) begin : g_bad_map
         $error("irq_enable_priority_regs: base plus eight must be 15");
      end
      if ((1 << VEC_W) < NUM_SRC) begin : g_bad_vec
         $error("irq_enable_priority_regs: vector too narrow");
      end
   endgenerate

   // register storage; the fixed top bit of base priority has no flop
   logic [6:0]       base_prio_r;
   logic [7:0]       ext_en1_r;
   logic [7:0]       ext_prio1_r;
   logic [7:0]       rdata_nxt;
   logic             hit_nxt;

   // service tracking
   logic             svc_high_r;
   logic             svc_low_r;
   seq_state_t       state_r;
   seq_state_t       state_nxt;

   // request selection
   logic [14:0]      pending;
   logic [14:0]      enabled;
   logic [14:0]      level;
   logic [14:0]      gated;
   logic [14:0]      high_cand;
   logic [14:0]      low_cand;
   logic             high_hit;
   logic             low_hit;
   logic [VEC_W-1:0] high_idx;
   logic [VEC_W-1:0] low_idx;
   logic             req_nxt;
   logic [VEC_W-1:0] vec_nxt;
   logic             high_nxt;
   logic             req_r;
   logic [VEC_W-1:0] vec_r;
   logic             high_r;

   // address match used by both write and read paths
   function automatic logic is_addr(input logic [7:0] a,
                                    input logic [7:0] ref_a);
      is_addr = (a == ref_a);
   endfunction : is_addr

   // base priority register; writes to the top bit are dropped
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         base_prio_r <= BASE_PRIO_RESET[6:0];
      end else if (sfr_wr_i && is_addr(sfr_addr_i, BASE_PRIO_ADDR)) begin
         base_prio_r <= sfr_wdata_i[6:0];
      end
   end

   // extended enable register one
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ext_en1_r <= EXT_EN1_RESET;
      end else if (sfr_wr_i && is_addr(sfr_addr_i, EXT_EN1_ADDR)) begin
         ext_en1_r <= sfr_wdata_i;
      end
   end

   // extended priority register one
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ext_prio1_r <= EXT_PRIO1_RESET;
      end else if (sfr_wr_i && is_addr(sfr_addr_i, EXT_PRIO1_ADDR)) begin
         ext_prio1_r <= sfr_wdata_i;
      end
   end

   // read mux; unmapped addresses answer zero with no hit
   always_comb begin
      rdata_nxt = 8'h00;
      hit_nxt   = 1'b1;
      if (is_addr(sfr_addr_i, BASE_PRIO_ADDR)) begin
         rdata_nxt = {1'b1, base_prio_r};
      end else if (is_addr(sfr_addr_i, EXT_EN1_ADDR)) begin
         rdata_nxt = ext_en1_r;
      end else if (is_addr(sfr_addr_i, EXT_PRIO1_ADDR)) begin
         rdata_nxt = ext_prio1_r;
      end else begin
         hit_nxt = 1'b0;
      end
   end

   // read data is held until the next read strobe
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         sfr_rdata_o <= 8'h00;
         sfr_hit_o   <= 1'b0;
      end else if (sfr_rd_i) begin
         sfr_rdata_o <= rdata_nxt;
         sfr_hit_o   <= hit_nxt;
      end
   end

   // pending per vector; shared sources are or-ed before the mask
   always_comb begin
      pending[6:0] = base_pending_i;
      pending[7]   = smbus_pending_i;
      pending[8]   = rtc_alarm_flag_i
                   | rtc_osc_failure_flag_i;
      pending[9]   = window_compare_flag_i;
      pending[10]  = conversion_done_flag_i;
      pending[11]  = counter_array_pending_i;
      pending[12]  = comparator_zero_rise_flag_i
                   | comparator_zero_fall_flag_i;
      pending[13]  = comparator_one_rise_flag_i
                   | comparator_one_fall_flag_i;
      pending[14]  = timer_three_low_overflow_i
                   | timer_three_high_overflow_i;
   end

   // enable and level per vector: base sources then extended ones
   always_comb begin
      enabled[6:0]  = basic_enable_i;
      level[6:0]    = base_prio_r;
      enabled[14:7] = ext_en1_r;
      level[14:7]   = ext_prio1_r;
   end

   // global gate wins over every individual mask
   assign gated = pending & enabled & {15{global_irq_gate_i}};

   // per-vector view, before level and service blocking
   assign gated_req_o = gated;

   // a level may only interrupt when no equal-or-higher service runs
   always_comb begin
      high_cand = gated & level & {15{~svc_high_r}};
      low_cand  = gated & ~level
                & {15{~svc_high_r & ~svc_low_r}};
   end

   // one picker per level keeps the tie order per level
   irq_pick_lowest #(
      .N (NUM_SRC),
      .W (VEC_W)
   ) u_pick_high (
      .req_i (high_cand),
      .hit_o (high_hit),
      .idx_o (high_idx)
   );

   irq_pick_lowest #(
      .N (NUM_SRC),
      .W (VEC_W)
   ) u_pick_low (
      .req_i (low_cand),
      .hit_o (low_hit),
      .idx_o (low_idx)
   );

   // high level first, lowest vector within a level
   always_comb begin
      req_nxt  = 1'b0;
      vec_nxt  = '0;
      high_nxt = 1'b0;
      if (state_r == ST_RUN && !irq_ack_i) begin
         if (high_hit) begin
            req_nxt  = 1'b1;
            vec_nxt  = high_idx;
            high_nxt = 1'b1;
         end else if (low_hit) begin
            req_nxt = 1'b1;
            vec_nxt = low_idx;
         end
      end
   end

   // request line; cleared at the edge that ends the ack cycle so one grant means one entry
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         req_r <= 1'b0;
      end else begin
         req_r <= req_nxt;
      end
   end

   // vector and level registered so they are stable when the core samples
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         vec_r  <= '0;
         high_r <= 1'b0;
      end else begin
         vec_r  <= vec_nxt;
         high_r <= high_nxt;
      end
   end

   // registered request outputs
   assign irq_req_o    = req_r;
   assign irq_vector_o = vec_r;
   assign irq_high_o   = high_r;

   // high in-service: set by a high grant, cleared by its return
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         svc_high_r <= 1'b0;
      end else if (irq_ack_i && req_r && high_r) begin
         svc_high_r <= 1'b1;
      end else if (reti_i) begin
         svc_high_r <= 1'b0;
      end
   end

   // low in-service: a return closes it only when no high routine nests
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         svc_low_r <= 1'b0;
      end else if (irq_ack_i && req_r && !high_r) begin
         svc_low_r <= 1'b1;
      end else if (reti_i && !svc_high_r) begin
         svc_low_r <= 1'b0;
      end
   end

   // in-service views for the core
   assign in_service_high_o = svc_high_r;
   assign in_service_low_o  = svc_low_r;

   // after a return, one more instruction completes before any request
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN: begin
            if (reti_i) begin
               state_nxt = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (instr_done_i) begin
               state_nxt = ST_RUN;
            end
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   // sequencer state
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_r <= ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

endmodule : irq_enable_priority_regs

// ===== rtl/irq_regs_pkg.sv
package irq_regs_pkg;

   // register addresses in the special-function space
   localparam logic [7:0] BASE_PRIO_ADDR = 8'hB8;
   localparam logic [7:0] EXT_EN1_ADDR   = 8'hE6;
   localparam logic [7:0] EXT_PRIO1_ADDR = 8'hF6;

   // reset values
   localparam logic [7:0] BASE_PRIO_RESET = 8'h80;
   localparam logic [7:0] EXT_EN1_RESET   = 8'h00;
   localparam logic [7:0] EXT_PRIO1_RESET = 8'h00;

   // base priority field positions
   localparam int BASE_FIXED_BIT  = 7;
   localparam int SERIAL_LVL_BIT  = 6;
   localparam int TIMER2_LVL_BIT  = 5;
   localparam int UART_LVL_BIT    = 4;
   localparam int TIMER1_LVL_BIT  = 3;
   localparam int EXT1_LVL_BIT    = 2;
   localparam int TIMER0_LVL_BIT  = 1;
   localparam int EXT0_LVL_BIT    = 0;

   // extended enable and priority share these positions
   localparam int TIMER3_BIT      = 7;
   localparam int CMP1_BIT        = 6;
   localparam int CMP0_BIT        = 5;
   localparam int CNT_ARRAY_BIT   = 4;
   localparam int CONV_DONE_BIT   = 3;
   localparam int CONV_WIN_BIT    = 2;
   localparam int RTC_BIT         = 1;
   localparam int SMBUS_BIT       = 0;

   // sources: index is the vector number and the tie order
   localparam int NUM_SRC         = 15;
   localparam int NUM_BASE_SRC    = 7;
   localparam int VEC_W           = 4;

   // sequencer after a return from service
   typedef enum logic [1:0] {
      ST_RUN  = 2'b01,
      ST_HOLD = 2'b10
   } seq_state_t;

endpackage : irq_regs_pkg

// ===== rtl/irq_pick_lowest.sv
`timescale 1ns/100ps
// fixed-order picker: the lowest set request index wins
module irq_pick_lowest #(
   parameter int N = 15,
   parameter int W = 4
) (
   // requests
   input  wire logic [N-1:0] req_i,
   // winner
   output logic             hit_o,
   output logic [W-1:0]     idx_o
);

   generate
      if (N < 1 || (1 << W) < N) begin : g_bad_cfg
         $error("irq_pick_lowest: N must fit in W bits");
      end
   endgenerate

   // scan from the top so the lowest index is written last
   always_comb begin
      hit_o = 1'b0;
      idx_o = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req_i[i]) begin
            hit_o = 1'b1;
            idx_o = W'(i);
         end
      end
   end

endmodule : irq_pick_lowest

// ===== bench/irq_regs_asserts.sv
`timescale 1ns/100ps
// port-level checks of masks, gate and service order
module irq_regs_asserts (
   // clock and reset
   input wire logic        clk_i,
   input wire logic        reset_n_i,
   // register access
   input wire logic [7:0]  sfr_addr_i,
   input wire logic        sfr_wr_i,
   input wire logic [7:0]  sfr_wdata_i,
   input wire logic        sfr_rd_i,
   input wire logic [7:0]  sfr_rdata_o,
   // gate, sources and service
   input wire logic        global_irq_gate_i,
   input wire logic        timer_three_low_overflow_i,
   input wire logic        timer_three_high_overflow_i,
   input wire logic        irq_ack_i,
   input wire logic        reti_i,
   // requests
   input wire logic        irq_req_o,
   input wire logic        irq_high_o,
   input wire logic [14:0] gated_req_o,
   input wire logic        in_service_high_o,
   input wire logic        in_service_low_o
);
   logic [7:0] en_r;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // shadow of the enable register, kept from observed writes
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         en_r <= 8'h00;
      end else if (sfr_wr_i && sfr_addr_i == 8'hE6) begin
         en_r <= sfr_wdata_i;
      end
   end
   property p_top; sfr_rd_i && sfr_addr_i == 8'hB8 |=> sfr_rdata_o[7];
   endproperty
   a_top: assert property (p_top)
      else $error("top bit read as 0");
   property p_en; sfr_rd_i && sfr_addr_i == 8'hE6 |=>
      sfr_rdata_o == $past(en_r); endproperty
   a_en: assert property (p_en)
      else $error("enable readback wrong");
   property p_t3; gated_req_o[14] == (global_irq_gate_i && en_r[7] &&
      (timer_three_low_overflow_i || timer_three_high_overflow_i));
   endproperty
   a_t3: assert property (p_t3)
      else $error("timer3 gating wrong");
   property p_off; !global_irq_gate_i |->
      gated_req_o == 15'h0000 ##1 !irq_req_o; endproperty
   a_off: assert property (p_off)
      else $error("request with gate shut");
   property p_ack; irq_ack_i |=> !irq_req_o; endproperty
   a_ack: assert property (p_ack)
      else $error("request held after ack");
   property p_hi; in_service_high_o |-> !irq_req_o; endproperty
   a_hi: assert property (p_hi)
      else $error("request during high service");
   property p_pre; in_service_low_o && irq_req_o |-> irq_high_o;
   endproperty
   a_pre: assert property (p_pre)
      else $error("low request during low service");
   property p_ret; reti_i && in_service_high_o |=>
      !in_service_high_o && !irq_req_o; endproperty
   a_ret: assert property (p_ret)
      else $error("return did not hold requests");
   property p_hold; reti_i |-> ##2 !irq_req_o; endproperty
   a_hold: assert property (p_hold)
      else $error("request during return hold");
   c_nest: cover property (in_service_low_o && in_service_high_o);
   c_pre: cover property (irq_req_o && irq_high_o && in_service_low_o);
   c_off: cover property (!global_irq_gate_i && sfr_rd_i);
endmodule : irq_regs_asserts
bind irq_enable_priority_regs irq_regs_asserts i_irq_regs_asserts (
   .clk_i, .reset_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i,
   .sfr_rdata_o, .global_irq_gate_i, .timer_three_low_overflow_i,
   .timer_three_high_overflow_i, .irq_ack_i, .reti_i, .irq_req_o,
   .irq_high_o, .gated_req_o, .in_service_high_o, .in_service_low_o
);

// ===== bench/core_model.sv
`timescale 1ns/100ps
// core side: takes offered requests, returns after LEN cycles
module core_model #(
   parameter int LEN = 8
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   // request and pacing
   input  wire logic req_i,
   input  wire logic go_i,
   // service handshake
   output logic      ack_o,
   output logic      reti_o,
   output logic      done_o
);
   logic [1:0] depth_r;
   logic [3:0] cnt_r;
   // innermost routine returns first; a new ack may nest on top
   always_ff @(posedge clk_i) begin
      ack_o  <= 1'b0;
      reti_o <= 1'b0;
      done_o <= reti_o & reset_n_i;
      if (!reset_n_i) begin
         depth_r <= 2'h0;
         cnt_r   <= 4'h0;
      end else if (req_i && go_i && !ack_o) begin
         ack_o   <= 1'b1;
         depth_r <= depth_r + 2'h1;
         cnt_r   <= 4'(LEN);
      end else if (cnt_r != 4'h0) begin
         cnt_r   <= cnt_r - 4'h1;
      end else if (depth_r != 2'h0 && !reti_o && !done_o) begin
         reti_o  <= 1'b1;
         depth_r <= depth_r - 2'h1;
         cnt_r   <= 4'(LEN);
      end
   end
endmodule : core_model

// ===== bench/testbench.sv
`timescale 1ns/100ps
// random and directed checks of masks, levels and service order
module testbench;
   logic        clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic [7:0]  sfr_addr_i = 8'h00;
   logic [7:0]  sfr_wdata_i = 8'h00;
   logic        sfr_wr_i = 1'b0;
   logic        sfr_rd_i = 1'b0;
   logic        global_irq_gate_i = 1'b0;
   logic [6:0]  basic_enable_i = 7'h00;
   logic [6:0]  base_pending_i = 7'h00;
   logic [11:0] fl = 12'h000;
   logic        go = 1'b0;
   logic [31:0] seed = 32'hE9B5;
   logic [7:0]  sfr_rdata_o;
   logic [3:0]  irq_vector_o;
   logic [14:0] gated_req_o;
   logic        sfr_hit_o, irq_ack_i, reti_i, instr_done_i, irq_req_o;
   logic        irq_high_o, in_service_high_o, in_service_low_o;
   int          bad_count = 0;
   int          num_checks = 0;
   irq_enable_priority_regs i_irq_enable_priority_regs (
      .clk_i, .reset_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i,
      .sfr_rdata_o, .sfr_hit_o, .global_irq_gate_i, .basic_enable_i,
      .base_pending_i, .smbus_pending_i(fl[0]), .rtc_alarm_flag_i(fl[1]),
      .rtc_osc_failure_flag_i(fl[2]), .window_compare_flag_i(fl[3]),
      .conversion_done_flag_i(fl[4]), .counter_array_pending_i(fl[5]),
      .comparator_zero_rise_flag_i(fl[6]),
      .comparator_zero_fall_flag_i(fl[7]),
      .comparator_one_rise_flag_i(fl[8]),
      .comparator_one_fall_flag_i(fl[9]),
      .timer_three_low_overflow_i(fl[10]),
      .timer_three_high_overflow_i(fl[11]), .irq_ack_i, .reti_i,
      .instr_done_i, .irq_req_o, .irq_vector_o, .irq_high_o, .gated_req_o,
      .in_service_high_o, .in_service_low_o
   );
   core_model i_core_model (
      .clk_i, .reset_n_i, .req_i(irq_req_o), .go_i(go), .ack_o(irq_ack_i),
      .reti_o(reti_i), .done_o(instr_done_i)
   );
   // 10 MHz clock
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   task automatic tick;
      @(posedge clk_i);
      #1;
   endtask : tick
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wreg(logic [7:0] a, logic [7:0] d);
      tick;
      sfr_addr_i  = a;
      sfr_wdata_i = d;
      sfr_wr_i    = 1'b1;
      tick;
      sfr_wr_i    = 1'b0;
   endtask : wreg
   // read data lands on the same edge that takes the strobe
   task automatic rchk(logic [7:0] a, logic [7:0] exp, logic h);
      tick;
      sfr_addr_i = a;
      sfr_rd_i   = 1'b1;
      tick;
      sfr_rd_i   = 1'b0;
      chk("read", {7'h00, sfr_hit_o, sfr_rdata_o}, {7'h00, h, exp});
   endtask : rchk
   // bounded wait for the core to take a request
   task automatic wait_ack(logic [3:0] v, logic h);
      int n = 0;
      while (irq_ack_i !== 1'b1) begin
         tick;
         n++;
         if (n > 60) begin
            chk("ack", 16'h0000, 16'h0001);
            summarize;
         end
      end
      chk("vector", {11'h000, irq_high_o, irq_vector_o}, {11'h000, h, v});
   endtask : wait_ack
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // shared flags fold into one request per source
   function automatic logic [14:0] exp_gated(logic [7:0] en, logic [6:0] e,
         logic [6:0] p, logic [11:0] f, logic g);
      logic [7:0] s;
      s = {f[11] | f[10], f[9] | f[8], f[7] | f[6], f[5:3],
         f[2] | f[1], f[0]};
      return g ? {s & en, p & e} : 15'h0000;
   endfunction : exp_gated
   // high level first, then lowest vector
   function automatic logic [15:0] exp_pick(logic [14:0] q, logic [14:0] lv);
      logic [14:0] h;
      h = q & lv;
      for (int i = 0; i < 15; i++) begin
         if ((h != 15'h0000) ? h[i] : q[i]) begin
            return {10'h000, 1'b1, lv[i], i[3:0]};
         end
      end
      return 16'h0000;
   endfunction : exp_pick
   initial begin
      logic [14:0] lv;
      logic [14:0] g;
      logic [7:0]  en;
      logic [15:0] ps;
      repeat (16) @(posedge clk_i);
      #1;
      reset_n_i = 1'b1;
      rchk(8'hB8, 8'h80, 1'b1);
      rchk(8'hE6, 8'h00, 1'b1);
      rchk(8'hF6, 8'h00, 1'b1);
      wreg(8'hE7, 8'hFF);
      rchk(8'hE7, 8'h00, 1'b0);
      $display("test reset and map done");
      // random masks, levels and pendings, no service taken
      repeat (40) begin
         repeat (9) seed = lfsr(seed);
         en = seed[7:0];
         lv = {seed[15:8], seed[22:16]};
         wreg(8'hE6, en);
         wreg(8'hF6, seed[15:8]);
         wreg(8'hB8, seed[23:16]);
         rchk(8'hB8, {1'b1, seed[22:16]}, 1'b1);
         rchk(8'hF6, seed[15:8], 1'b1);
         repeat (9) seed = lfsr(seed);
         global_irq_gate_i = seed[3:0] != 4'h0;
         basic_enable_i = seed[10:4];
         base_pending_i = seed[17:11];
         fl = seed[29:18];
         g = exp_gated(en, basic_enable_i, base_pending_i, fl,
            global_irq_gate_i);
         tick;
         tick;
         chk("gated", {1'b0, gated_req_o}, {1'b0, g});
         ps = {10'h000, irq_req_o, irq_high_o, irq_vector_o};
         chk("pick", ps, exp_pick(g, lv));
      end
      $display("test random masks done");
      // all pending and unmasked while the global gate is shut
      wreg(8'hE6, 8'hFF);
      rchk(8'hE6, 8'hFF, 1'b1);
      basic_enable_i = 7'h7F;
      base_pending_i = 7'h7F;
      fl = 12'hFFF;
      global_irq_gate_i = 1'b0;
      tick;
      tick;
      chk("gate off", {irq_req_o, gated_req_o}, 16'h0000);
      // low service, equal level held off, high preempts, then resume
      wreg(8'hB8, 8'h00);
      wreg(8'hF6, 8'h80);
      fl = 12'h000;
      base_pending_i = 7'h01;
      global_irq_gate_i = 1'b1;
      go = 1'b1;
      wait_ack(4'h0, 1'b0);
      base_pending_i = 7'h02;
      repeat (4) tick;
      chk("held", 16'({in_service_low_o, irq_req_o}), 16'h0002);
      fl = 12'h800;
      wait_ack(4'hE, 1'b1);
      fl = 12'h000;
      tick;
      chk("nested", 16'({in_service_high_o, in_service_low_o}),
         16'h0003);
      wait_ack(4'h1, 1'b0);
      base_pending_i = 7'h00;
      $display("test service order done");
      summarize;
   end
endmodule : testbench
